// [core/sbtm_core.sv]
// Sixteen-bit timer with compare, PWM, single-pulse and capture modes on AXI4-Lite.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Read-only counter high byte, reset zero.
// - Sixteen-bit compare A in two bytes, reset zero.
// - Compare P against counter high byte; zero overflows.
// - Two-bit mode field selects operating mode.
// - Compare mode, clear on P: clear, both flags.
// - Compare mode, clear on A: only A flag.
// - Compare mode pin changes on A match, never on P match.
// - Run rising edge loads initial pin level.
// - Timer/counter mode counts like compare, pin undriven.
// - PWM: one register period, other duty, swappable.
// - PWM raises A and P match flags.
// - PWM active level, forcing, polarity inversion.
// - PWM generator keeps running while forced.
// - Unswapped: period P times 256, duty A.
// - Swapped: period A, duty P times 256.
// - Duty at or above period gives full duty.
// - Single pulse starts on run rise or trigger.
// - Single pulse ends on run clear or A match.
// - Single pulse: A match flag; run rise zeroes counter.
// - Mode 01 captures counter into compare A.
module sbtm_core #(
  parameter int unsigned TICK_DIV = sbtm_pkg::TICK_DIV_DEFAULT
) (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        EXT_TRIG_I,
  input  wire logic        CAPT_I,
  output logic             TIMER_OUT_O,
  output logic             TIMER_OUT_OE_O,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [5:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  output logic [1:0]       S_AXI_BRESP_O,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  input  wire logic [5:0]  S_AXI_ARADDR_I,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: address and data are held until both are present.

  logic                aw_full;
  logic                w_full;
  logic [5:0]          aw_addr;
  logic [7:0]          w_byte;
  logic                w_lane0;

  wire aw_take = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
  wire w_take  = S_AXI_WVALID_I & S_AXI_WREADY_O;
  wire wr_fire = aw_full & w_full & ~S_AXI_BVALID_O;
  wire [5:0] wa = {aw_addr[5:2], 2'b00};
  wire wa_ok = (wa < sbtm_pkg::REG_SPAN);
  wire wr_en = wr_fire & w_lane0;

  assign S_AXI_AWREADY_O = ~aw_full & ~S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = ~w_full & ~S_AXI_BVALID_O;
  assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;

  wire wr_run  = wr_en & (wa == sbtm_pkg::OFF_RUN);
  wire wr_ctrl = wr_en & (wa == sbtm_pkg::OFF_CTRL);
  wire wr_cal  = wr_en & (wa == sbtm_pkg::OFF_CA_LO);
  wire wr_cah  = wr_en & (wa == sbtm_pkg::OFF_CA_HI);
  wire wr_cp   = wr_en & (wa == sbtm_pkg::OFF_CP);
  wire wr_stat = wr_en & (wa == sbtm_pkg::OFF_STAT);

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      aw_full        <= 1'b0;
      w_full         <= 1'b0;
      aw_addr        <= 6'h00;
      w_byte         <= sbtm_pkg::RST_BYTE;
      w_lane0        <= 1'b0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= sbtm_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
      end
      if (w_take)
      begin
        w_full  <= 1'b1;
        w_byte  <= S_AXI_WDATA_I[7:0];
        w_lane0 <= S_AXI_WSTRB_I[0];
      end
      if (wr_fire)
      begin
        aw_full        <= 1'b0;
        w_full         <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= wa_ok ? sbtm_pkg::RESP_OKAY : sbtm_pkg::RESP_SLVERR;
      end
      else if (S_AXI_BREADY_I)
        S_AXI_BVALID_O <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer state.

  sbtm_pkg::sbtm_ctrl_s ctrl;
  logic                 run;
  logic [15:0]          cnt;
  logic [7:0]           ca_lo;
  logic [7:0]           ca_hi;
  logic [7:0]           cp;
  logic                 flag_a;
  logic                 flag_p;
  logic                 out_lvl;
  logic                 trig_q;
  logic                 capt_q;
  logic                 tick;

  sbtm_tick_div #(
    .DIV     (TICK_DIV)
  ) u_tick (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RST_N_I),
    .tick_o  (tick)
  );

  // Mode decode; pin action 11 under mode 10 means single pulse.
  wire is_cmp = (ctrl.mode == sbtm_pkg::SBTM_CMP);
  wire is_tc  = (ctrl.mode == sbtm_pkg::SBTM_TC);
  wire is_cap = (ctrl.mode == sbtm_pkg::SBTM_CAP);
  wire is_wav = (ctrl.mode == sbtm_pkg::SBTM_PWM);
  wire is_sp  = is_wav & (ctrl.pin_action == sbtm_pkg::PA_TOG);
  wire is_pwm = is_wav & ~is_sp;
  wire cmp_like = is_cmp | is_tc;

  // A match is the count about to reach the compare value.
  wire [15:0] cnt_inc = 16'(cnt + 16'h0001);
  wire [15:0] ca      = {ca_hi, ca_lo};
  wire        hit_a   = (cnt_inc == ca);
  wire        hit_p   = (cnt_inc == {cp, 8'h00});
  wire        step    = tick & run;

  // Clear source per mode.
  wire clr_cmp = ctrl.counter_clear_select ? hit_a : hit_p;
  wire clr_pwm = ctrl.period_duty_swap ? hit_a : hit_p;
  wire clr_cnt = cmp_like ? clr_cmp :
                 is_pwm   ? clr_pwm :
                 is_cap   ? hit_p   : 1'b0;

  // Match events feeding the flags.
  wire no_p  = is_sp | (cmp_like & ctrl.counter_clear_select);
  wire ev_a  = step & hit_a & ~is_cap;
  wire ev_p  = step & hit_p & ~no_p;

  // Capture edges on the capture pin.
  wire capt_rise = CAPT_I & ~capt_q;
  wire capt_fall = ~CAPT_I & capt_q;
  wire capt_edge = (ctrl.pin_action == sbtm_pkg::CAP_RISE) ? capt_rise :
                   (ctrl.pin_action == sbtm_pkg::CAP_FALL) ? capt_fall :
                   (ctrl.pin_action == sbtm_pkg::CAP_BOTH) ? (capt_rise | capt_fall) :
                   1'b0;
  wire cap_ev = is_cap & run & capt_edge;

  // Run bit: a trigger that starts the pulse wins over a clear.
  wire trig_rise = EXT_TRIG_I & ~trig_q;
  wire trig_set  = is_sp & trig_rise & ~run;
  wire next_run  = trig_set ? 1'b1 :
                   wr_run   ? w_byte[sbtm_pkg::RUN_BIT] :
                   (is_sp & ev_a) ? 1'b0 : run;
  wire run_rise  = next_run & ~run;

  wire [15:0] next_cnt = run_rise ? sbtm_pkg::RST_WORD :
                         ~step    ? cnt :
                         (clr_cnt ? sbtm_pkg::RST_WORD : cnt_inc);

  // Flags: a new event wins over a write-one-to-clear.
  wire clr_a = wr_stat & w_byte[sbtm_pkg::FLAG_A_BIT];
  wire clr_p = wr_stat & w_byte[sbtm_pkg::FLAG_P_BIT];
  wire next_flag_a = ev_a | cap_ev | (flag_a & ~clr_a);
  wire next_flag_p = ev_p | (flag_p & ~clr_p);

  // Compare-mode pin level: initial level on run rise, then driven by A matches only.
  wire cmp_new = (ctrl.pin_action == sbtm_pkg::PA_LOW)  ? 1'b0 :
                 (ctrl.pin_action == sbtm_pkg::PA_HIGH) ? 1'b1 :
                 (ctrl.pin_action == sbtm_pkg::PA_TOG)  ? ~out_lvl : out_lvl;
  wire next_out_lvl = run_rise ? ctrl.output_initial_level :
                      (is_cmp & ev_a) ? cmp_new : out_lvl;

  // PWM duty compare; compare P of zero stands for 65536.
  wire [16:0] duty_p  = {(cp == 8'h00), cp, 8'h00};
  wire [16:0] duty    = ctrl.period_duty_swap ? duty_p : {1'b0, ca};
  wire        duty_on = ({1'b0, cnt} < duty);
  wire pwm_act = is_sp ? run :
                 (ctrl.pin_action == sbtm_pkg::PA_LOW)  ? 1'b1 :
                 (ctrl.pin_action == sbtm_pkg::PA_HIGH) ? duty_on : 1'b0;
  wire pwm_lvl = pwm_act ? ctrl.output_initial_level :
                 ~ctrl.output_initial_level;
  wire next_pin = (is_wav ? pwm_lvl : out_lvl) ^ ctrl.output_invert;

  wire [7:0] next_ca_lo = cap_ev ? cnt[7:0]  : wr_cal ? w_byte : ca_lo;
  wire [7:0] next_ca_hi = cap_ev ? cnt[15:8] : wr_cah ? w_byte : ca_hi;

  assign TIMER_OUT_OE_O = is_cmp | is_wav;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ctrl        <= sbtm_pkg::sbtm_ctrl_s'(sbtm_pkg::RST_BYTE);
      run         <= 1'b0;
      cnt         <= sbtm_pkg::RST_WORD;
      ca_lo       <= sbtm_pkg::RST_BYTE;
      ca_hi       <= sbtm_pkg::RST_BYTE;
      cp          <= sbtm_pkg::RST_BYTE;
      flag_a      <= 1'b0;
      flag_p      <= 1'b0;
      out_lvl     <= 1'b0;
      trig_q      <= 1'b0;
      capt_q      <= 1'b0;
      TIMER_OUT_O <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= sbtm_pkg::sbtm_ctrl_s'(w_byte);
      if (wr_cp)
        cp <= w_byte;
      run         <= next_run;
      cnt         <= next_cnt;
      ca_lo       <= next_ca_lo;
      ca_hi       <= next_ca_hi;
      flag_a      <= next_flag_a;
      flag_p      <= next_flag_p;
      out_lvl     <= next_out_lvl;
      trig_q      <= EXT_TRIG_I;
      capt_q      <= CAPT_I;
      TIMER_OUT_O <= next_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: one registered answer per accepted address.

  wire [5:0] ra    = {S_AXI_ARADDR_I[5:2], 2'b00};
  wire       ra_ok = (ra < sbtm_pkg::REG_SPAN);
  wire [7:0] rd_byte =
    (ra == sbtm_pkg::OFF_RUN)    ? {7'h00, run} :
    (ra == sbtm_pkg::OFF_CTRL)   ? 8'(ctrl) :
    (ra == sbtm_pkg::OFF_CNT_LO) ? cnt[7:0] :
    (ra == sbtm_pkg::OFF_CNT_HI) ? cnt[15:8] :
    (ra == sbtm_pkg::OFF_CA_LO)  ? ca_lo :
    (ra == sbtm_pkg::OFF_CA_HI)  ? ca_hi :
    (ra == sbtm_pkg::OFF_CP)     ? cp :
    (ra == sbtm_pkg::OFF_STAT)   ? {6'h00, flag_p, flag_a} : 8'h00;
  wire ar_take = S_AXI_ARVALID_I & S_AXI_ARREADY_O;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= 32'h0000_0000;
      S_AXI_RRESP_O  <= sbtm_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O  <= {24'h00_0000, rd_byte};
      S_AXI_RRESP_O  <= ra_ok ? sbtm_pkg::RESP_OKAY : sbtm_pkg::RESP_SLVERR;
    end
    else if (S_AXI_RREADY_I)
      S_AXI_RVALID_O <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_run_zeroes_cnt: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    $rose(run) |-> (cnt[15:8] == 8'h00) && (cnt[7:0] == 8'h00))
    else $error("Counter not zero after run rise.");

  chk_ca_byte_write: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (wr_cah && !cap_ev) |=> (ca[15:8] == $past(w_byte)))
    else $error("Compare A high byte not written.");

  chk_p_clears_cnt: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (step && cmp_like && !ctrl.counter_clear_select && !wr_run && cnt == {cp - 8'h01, 8'hFF})
    |=> (cnt == 16'h0000) && flag_p)
    else $error("Compare P match did not clear counter.");

  chk_a_only_flag: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (cmp_like && ctrl.counter_clear_select && !flag_p) |=> !flag_p)
    else $error("P flag raised with clear on A.");

  chk_pin_toggle: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (is_cmp && step && hit_a && ctrl.pin_action == 2'h3 && !ctrl.output_invert)
    ##1 !wr_ctrl |=> (TIMER_OUT_O != $past(TIMER_OUT_O, 2)))
    else $error("Pin did not toggle on A match.");

  chk_run_init_lvl: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (is_cmp && $rose(run) && !wr_ctrl && !ev_a)
    |=> (TIMER_OUT_O == (ctrl.output_initial_level ^ ctrl.output_invert)))
    else $error("Pin not at initial level after run rise.");

  chk_tc_undriven: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (ctrl.mode == 2'b11) |-> !TIMER_OUT_OE_O)
    else $error("Pin driven in timer/counter mode.");

  chk_pwm_full_duty: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (is_pwm && ctrl.period_duty_swap && cp == 8'h00 && ctrl.pin_action == 2'h2)[*2]
    |-> (TIMER_OUT_O == (ctrl.output_initial_level ^ ctrl.output_invert)))
    else $error("Full duty not held active.");

  chk_pwm_forced: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (is_pwm && ctrl.pin_action == 2'h0)[*2]
    |-> (TIMER_OUT_O == !(ctrl.output_initial_level ^ ctrl.output_invert)))
    else $error("Forced inactive level not held.");

  chk_sp_stop: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (is_sp && step && hit_a && !wr_run) |=> !run ##1 (TIMER_OUT_O ==
      !(ctrl.output_initial_level ^ ctrl.output_invert)))
    else $error("Single pulse not ended by A match.");

  chk_trig_start: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (is_sp && EXT_TRIG_I && !$past(EXT_TRIG_I) && !run) |=> run && cnt == 16'h0000)
    else $error("Trigger did not start single pulse.");

  chk_capture: assert property (
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    (cap_ev) |=> (ca == $past(cnt)) && flag_a)
    else $error("Capture did not latch counter.");

endmodule // sbtm_core

// [core/sbtm_pkg.sv]
// Shared constants, types and register map for the sixteen-bit timer.
package sbtm_pkg;

  // Register byte offsets on the AXI4-Lite port.
  localparam int unsigned AXI_ADDR_W = 6;
  localparam logic [5:0]  OFF_RUN    = 6'h00;
  localparam logic [5:0]  OFF_CTRL   = 6'h04;
  localparam logic [5:0]  OFF_CNT_LO = 6'h08;
  localparam logic [5:0]  OFF_CNT_HI = 6'h0C;
  localparam logic [5:0]  OFF_CA_LO  = 6'h10;
  localparam logic [5:0]  OFF_CA_HI  = 6'h14;
  localparam logic [5:0]  OFF_CP     = 6'h18;
  localparam logic [5:0]  OFF_STAT   = 6'h1C;
  localparam logic [5:0]  REG_SPAN   = 6'h20;

  // Field positions and reset values.
  localparam int unsigned RUN_BIT    = 0;
  localparam int unsigned FLAG_A_BIT = 0;
  localparam int unsigned FLAG_P_BIT = 1;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;

  // AXI response codes.
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Pin-action encodings.
  localparam logic [1:0]  PA_NONE  = 2'h0;
  localparam logic [1:0]  PA_LOW   = 2'h1;
  localparam logic [1:0]  PA_HIGH  = 2'h2;
  localparam logic [1:0]  PA_TOG   = 2'h3;
  localparam logic [1:0]  CAP_RISE = 2'h0;
  localparam logic [1:0]  CAP_FALL = 2'h1;
  localparam logic [1:0]  CAP_BOTH = 2'h2;

  // Timer clock divider, timer clock equals system clock by default.
  localparam int unsigned TICK_DIV_DEFAULT = 1;

  typedef enum logic [1:0] {
    SBTM_CMP = 2'b00,
    SBTM_CAP = 2'b01,
    SBTM_PWM = 2'b10,
    SBTM_TC  = 2'b11
  } sbtm_mode_e;

  // Control byte layout, bit 7 down to bit 0.
  typedef struct packed {
    sbtm_mode_e mode;
    logic [1:0] pin_action;
    logic       output_initial_level;
    logic       output_invert;
    logic       period_duty_swap;
    logic       counter_clear_select;
  } sbtm_ctrl_s;

endpackage

// [core/sbtm_tick_div.sv]
// Timer clock enable divider.
`timescale 1ns/1ps

module sbtm_tick_div #(
  parameter int unsigned DIV = 1
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);

  localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;

  logic [W-1:0] cnt;
  wire          last = (cnt == W'(DIV - 1));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt    <= last ? '0 : W'(cnt + 1'b1);
      tick_o <= last;
    end
  end

endmodule // sbtm_tick_div

// [tb/sbtm_pin_model.sv]
// Pin-side model of the timer: pulled-up output pin, trigger and capture drivers.
`timescale 1ns/1ps

module sbtm_pin_model (
  input  wire logic clk_i,
  input  wire logic pin_i,
  input  wire logic oe_i,
  input  wire logic meas_i,
  input  wire logic trig_req_i,
  input  wire logic capt_req_i,
  output logic      trig_o,
  output logic      capt_o,
  output int        hi_cnt_o
);
  // A pin that the timer does not drive floats to the pull-up level.
  wire logic lvl = oe_i ? pin_i : 1'b1;

  always @(posedge clk_i)
  begin
    trig_o   <= trig_req_i;
    capt_o   <= capt_req_i;
    hi_cnt_o <= meas_i ? hi_cnt_o + int'(lvl) : 0;
  end
endmodule // sbtm_pin_model

// [tb/sixteen_bit_timer_module_tb_top.sv]
// Self-checking bench for the timer core over AXI4-Lite and its output pin.
`timescale 1ns/1ps

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module sixteen_bit_timer_module_tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0;
  logic        arv = 1'b0, rre = 1'b0, trq = 1'b0, crq = 1'b0, meas = 1'b0;
  logic [5:0]  awa = 6'h00, ara = 6'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic        awr, wr_r, bv, arr, rv, pin, oe, trig, capt;
  logic [1:0]  br, rr, wr_resp;
  logic [31:0] rd;
  int          hi, err_total = 0, checked = 0;
  integer      seed = 32'h4d53;
  localparam logic [5:0] ROFF [4] = '{sbtm_pkg::OFF_CNT_HI, sbtm_pkg::OFF_CA_LO,
                                      sbtm_pkg::OFF_CA_HI, sbtm_pkg::OFF_CP};
  localparam logic [7:0] CMPC [6] = '{8'h09, 8'h19, 8'h21, 8'h39, 8'h38, 8'hF9};
  localparam logic [7:0] PWMC [7] = '{8'hAA, 8'hA8, 8'hA8, 8'hAC, 8'h88, 8'h98, 8'hA0};

  always #25 clk = ~clk;

  sbtm_core DUT (.SYS_CLK_I(clk), .RST_N_I(rst_n), .EXT_TRIG_I(trig), .CAPT_I(capt),
    .TIMER_OUT_O(pin), .TIMER_OUT_OE_O(oe), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_AWADDR_I(awa), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_r), .S_AXI_WDATA_I(wd),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre), .S_AXI_BRESP_O(br),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rre), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr));

  sbtm_pin_model u_pin (.clk_i(clk), .pin_i(pin), .oe_i(oe), .meas_i(meas),
    .trig_req_i(trq), .capt_req_i(crq), .trig_o(trig), .capt_o(capt), .hi_cnt_o(hi));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic ha, hw, ta, tw, hb;
    ta = 1'b0;
    tw = 1'b0;
    hb = 1'b0;
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    while (!(ta && tw))
    begin
      @(negedge clk);
      ha = awv && awr;
      hw = wv && wr_r;
      @(posedge clk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
      ta |= ha;
      tw |= hw;
    end
    bre <= 1'b1;
    while (!hb)
    begin
      @(negedge clk);
      hb = bv;
      wr_resp = br;
      @(posedge clk);
    end
    bre <= 1'b0;
  endtask

  task automatic chk_rd(input logic [5:0] a, input logic [7:0] e, input logic [1:0] er);
    logic h, g;
    h = 1'b0;
    g = 1'b0;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    while (!g)
    begin
      @(negedge clk);
      if (h) g = rv;
      h |= arv && arr;
      @(posedge clk);
      if (h) arv <= 1'b0;
    end
    rre <= 1'b0;
    `CHK(rd, {24'h00_0000, e})
    `CHK(rr, er)
  endtask

  // Loads compare values and control, clears both flags, then writes the run argument to the run bit.
  task automatic cfg(input logic [7:0] c, input logic [15:0] ca, input logic [7:0] cp,
                     input logic run);
    wr(sbtm_pkg::OFF_RUN, 32'h0000_0000);
    wr(sbtm_pkg::OFF_CA_LO, {24'h00_0000, ca[7:0]});
    wr(sbtm_pkg::OFF_CA_HI, {24'h00_0000, ca[15:8]});
    wr(sbtm_pkg::OFF_CP, {24'h00_0000, cp});
    wr(sbtm_pkg::OFF_CTRL, {24'h00_0000, c});
    wr(sbtm_pkg::OFF_STAT, 32'h0000_0003);
    wr(sbtm_pkg::OFF_RUN, {31'h0000_0000, run});
  endtask

  task automatic measure(input int n, output int h);
    @(posedge clk);
    meas <= 1'b1;
    repeat (n) @(posedge clk);
    meas <= 1'b0;
    #1 h = hi;
  endtask

  task finish_test();
    if (err_total == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  function automatic int exp_cmp(input logic [7:0] c, input int w);
    if (c[7:6] == 2'b11 || c[5:4] == 2'b10) return w;
    if (c[5:4] == 2'b00) return c[3] ? w : 0;
    return (c[5:4] == 2'b01) ? 0 : w / 2;
  endfunction

  function automatic int exp_pwm(input logic [7:0] c, input int ca);
    int per, duty, act, lv;
    per = c[1] ? ca : 256;
    duty = c[1] ? 256 : ca;
    act = (duty >= per) ? per : duty;
    act = (c[5:4] == 2'b10) ? act : ((c[5:4] == 2'b01) ? per : 0);
    lv = c[3] ? act : per - act;
    return 2 * (c[2] ? per - lv : lv);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (80000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial
  begin
    logic [7:0]  c;
    logic [15:0] ca;
    logic [31:0] v;
    int          t, h;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROFF[i]) chk_rd(ROFF[i], 8'h00, sbtm_pkg::RESP_OKAY);
    chk_rd(6'h20, 8'h00, sbtm_pkg::RESP_SLVERR);
    wr(6'h20, 32'h0000_00FF);
    `CHK(wr_resp, sbtm_pkg::RESP_SLVERR)
    repeat (3)
      for (int i = 0; i < 4; i++)
      begin
        v = $random(seed);
        wr(ROFF[i], v);
        `CHK(wr_resp, sbtm_pkg::RESP_OKAY)
        chk_rd(ROFF[i], (i == 0) ? 8'h00 : v[7:0], sbtm_pkg::RESP_OKAY);
      end
    cfg(8'hF0, 16'h0000, 8'h00, 1'b1);
    repeat (300) @(posedge clk);
    chk_rd(sbtm_pkg::OFF_CNT_HI, 8'h01, sbtm_pkg::RESP_OKAY);
    for (int i = 0; i < 6; i++)
    begin
      c = CMPC[i];
      ca = (c[0] ? 16'd260 : 16'd60) + 16'($random(seed) & 31);
      t = c[0] ? int'(ca) : 256;
      cfg(c, ca, 8'h01, 1'b1);
      repeat (3) @(posedge clk);
      if (c[7:6] == 2'b00) `CHK(pin, c[3])
      else `CHK(oe, 1'b0)
      repeat (int'(ca) + 5) @(posedge clk);
      measure(4 * t, h);
      `CHK(h, exp_cmp(c, 4 * t))
      chk_rd(sbtm_pkg::OFF_STAT, {6'h00, !c[0], 1'b1}, sbtm_pkg::RESP_OKAY);
    end
    for (int i = 0; i < 7; i++)
    begin
      c = PWMC[i];
      ca = (i < 2) ? 16'd300 : 16'd1 + 16'($random(seed) & 127);
      t = c[1] ? int'(ca) : 256;
      cfg(c, ca, 8'h01, 1'b1);
      repeat (20) @(posedge clk);
      measure(2 * t, h);
      `CHK(h, exp_pwm(c, int'(ca)))
      chk_rd(sbtm_pkg::OFF_STAT, {6'h00, t >= 256, int'(ca) <= t}, 2'h0);
    end
    cfg(8'hAA, 16'd100, 8'h00, 1'b1);
    repeat (20) @(posedge clk);
    measure(200, h);
    `CHK(h, 200)
    chk_rd(sbtm_pkg::OFF_STAT, 8'h01, sbtm_pkg::RESP_OKAY);
    ca = 16'd40 + 16'($random(seed) & 15);
    cfg(8'hB8, ca, 8'h01, 1'b0);
    @(posedge clk);
    meas <= 1'b1;
    trq <= 1'b1;
    @(posedge clk);
    trq <= 1'b0;
    repeat (198) @(posedge clk);
    meas <= 1'b0;
    #1 h = hi;
    `CHK(h, int'(ca))
    chk_rd(sbtm_pkg::OFF_RUN, 8'h00, sbtm_pkg::RESP_OKAY);
    chk_rd(sbtm_pkg::OFF_STAT, 8'h01, sbtm_pkg::RESP_OKAY);
    cfg(8'hB8, 16'hFFFF, 8'h01, 1'b1);
    measure(100, h);
    `CHK(h, 100)
    wr(sbtm_pkg::OFF_RUN, 32'h0000_0000);
    repeat (3) @(posedge clk);
    measure(50, h);
    `CHK(h, 0)
    cfg(8'h40, 16'h0000, 8'h00, 1'b1);
    repeat (20) @(posedge clk);
    crq <= 1'b1;
    @(posedge clk);
    crq <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(oe, 1'b0)
    chk_rd(sbtm_pkg::OFF_STAT, 8'h01, sbtm_pkg::RESP_OKAY);
    finish_test();
  end
endmodule // sixteen_bit_timer_module_tb_top
